// ### eb_cfg_if.sv
// configuration bits handed from the register to the chip select router
`timescale 1ns/1ns
interface eb_cfg_if;
  logic cs1_sdram;
  logic cs3_nand;
  logic cs4_card;
  logic cs5_card;

  modport reg_side
  (
    output cs1_sdram,
    output cs3_nand,
    output cs4_card,
    output cs5_card
  );

  modport route_side
  (
    input cs1_sdram,
    input cs3_nand,
    input cs4_card,
    input cs5_card
  );
endinterface

// ### eb_cs_route.sv
// chip select router between the bus interface and the memory controllers
`timescale 1ns/1ns
module eb_cs_route
(
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic clk_en,
  eb_cfg_if.route_side cfg,
  input  wire logic cs1_req_n,
  input  wire logic cs3_req_n,
  input  wire logic cs4_req_n,
  input  wire logic cs5_req_n,
  input  wire logic cs6_req_n,
  output logic      static_cs1_n,
  output logic      sdram_cs_n,
  output logic      chip_select_three_n,
  output logic      chip_select_four_n,
  output logic      chip_select_five_n,
  output logic      chip_select_six_n,
  output logic      nand_select,
  output logic      card_select_four,
  output logic      card_select_five
);

  eb_pkg::eb_target_e cs1_target;

  // decode of the routing target of chip select one
  assign cs1_target = cfg.cs1_sdram ? eb_pkg::EB_TO_SDRAM : eb_pkg::EB_TO_STATIC;

  // chip select one goes to exactly one controller; the other sees it idle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      static_cs1_n <= 1'b1;
      sdram_cs_n   <= 1'b1;
    end
    else if (clk_en)
    begin
      static_cs1_n <= (cs1_target == eb_pkg::EB_TO_STATIC) ? cs1_req_n : 1'b1;
      sdram_cs_n   <= (cs1_target == eb_pkg::EB_TO_SDRAM) ? cs1_req_n : 1'b1;
    end
  end

  // selects three to six always stay with the static controller
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      chip_select_three_n <= 1'b1;
      chip_select_four_n  <= 1'b1;
      chip_select_five_n  <= 1'b1;
      chip_select_six_n   <= 1'b1;
    end
    else if (clk_en)
    begin
      chip_select_three_n <= cs3_req_n;
      chip_select_four_n  <= cs4_req_n;
      chip_select_five_n  <= cs5_req_n;
      chip_select_six_n   <= cs6_req_n;
    end
  end

  // special flash and card logic is woken only when its select is active and enabled
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      nand_select      <= 1'b0;
      card_select_four <= 1'b0;
      card_select_five <= 1'b0;
    end
    else if (clk_en)
    begin
      nand_select      <= cfg.cs3_nand & ~cs3_req_n;
      card_select_four <= cfg.cs4_card & ~cs4_req_n;
      card_select_five <= cfg.cs5_card & ~cs5_req_n;
    end
  end

endmodule

// ### eb_pin_cs_config.sv
// external bus pin pull-up and chip select assignment register
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module eb_pin_cs_config
(
  input  wire logic                             clock,
  input  wire logic                             rstn,
  input  wire logic                             clk_en,
  // register port
  input  wire logic [eb_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [eb_pkg::DATA_W-1:0]        reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [eb_pkg::DATA_W-1:0]        reg_rdata,
  // pull-up control
  input  wire logic [eb_pkg::SHARED_PINS-1:0]   gpio_pullup_req,
  output logic                                  data_bus_pullup_control,
  output logic      [eb_pkg::SHARED_PINS-1:0]   shared_pin_pullup,
  // chip select requests from the bus interface, active low
  input  wire logic                             cs1_req_n,
  input  wire logic                             cs3_req_n,
  input  wire logic                             cs4_req_n,
  input  wire logic                             cs5_req_n,
  input  wire logic                             cs6_req_n,
  // routed selects
  output logic                                  static_cs1_n,
  output logic                                  sdram_cs_n,
  output logic                                  chip_select_three_n,
  output logic                                  chip_select_four_n,
  output logic                                  chip_select_five_n,
  output logic                                  chip_select_six_n,
  // special logic enables and strobes
  output logic                                  nand_logic_enable,
  output logic                                  card_logic_enable,
  output logic                                  nand_select,
  output logic                                  card_select_four,
  output logic                                  card_select_five
);

  logic [eb_pkg::DATA_W-1:0] cfg_q;
  logic [eb_pkg::DATA_W-1:0] cfg_d;
  logic [eb_pkg::DATA_W-1:0] rdata_d;
  logic                      cfg_hit_wr;

  eb_cfg_if cfg_bus ();

  // single register decode, reused for reads and writes
  function automatic logic is_cfg_addr(input logic [eb_pkg::ADDR_W-1:0] a);
    is_cfg_addr = (a == eb_pkg::CFG_ADDR);
  endfunction

  assign cfg_hit_wr = reg_wr & is_cfg_addr(reg_addr);

  // only implemented bits take the write; reserved ones stay zero
  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_hit_wr)
    begin
      cfg_d = reg_wdata & eb_pkg::CFG_MASK;
    end
  end

  // configuration word
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= eb_pkg::CFG_RESET;
    end
    else if (clk_en)
    begin
      cfg_q <= cfg_d;
    end
  end

  // read mux; unmapped addresses answer zero so software sees no stale data
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd && is_cfg_addr(reg_addr))
    begin
      rdata_d = cfg_q & eb_pkg::CFG_MASK;
    end
    else if (reg_rd)
    begin
      rdata_d = '0;
    end
  end

  // read data is valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= '0;
    end
    else if (clk_en)
    begin
      reg_rdata <= rdata_d;
    end
  end

  // dedicated pins use the register bit; shared pins belong to the io controller
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      data_bus_pullup_control <= eb_pkg::CFG_RESET[eb_pkg::PULLUP_POS];
      shared_pin_pullup       <= '0;
    end
    else if (clk_en)
    begin
      data_bus_pullup_control <= cfg_q[eb_pkg::PULLUP_POS];
      shared_pin_pullup       <= gpio_pullup_req;
    end
  end

  // the card logic serves both select four and five, so either bit wakes it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      nand_logic_enable <= 1'b0;
      card_logic_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      nand_logic_enable <= cfg_q[eb_pkg::CS3_POS];
      card_logic_enable <= cfg_q[eb_pkg::CS4_POS] | cfg_q[eb_pkg::CS5_POS];
    end
  end

  // hand the assignment bits to the router
  assign cfg_bus.cs1_sdram = cfg_q[eb_pkg::CS1_POS];
  assign cfg_bus.cs3_nand  = cfg_q[eb_pkg::CS3_POS];
  assign cfg_bus.cs4_card  = cfg_q[eb_pkg::CS4_POS];
  assign cfg_bus.cs5_card  = cfg_q[eb_pkg::CS5_POS];

  // routing of the select lines
  eb_cs_route u_route
  (
    .clock               (clock),
    .rstn                (rstn),
    .clk_en              (clk_en),
    .cfg                 (cfg_bus.route_side),
    .cs1_req_n           (cs1_req_n),
    .cs3_req_n           (cs3_req_n),
    .cs4_req_n           (cs4_req_n),
    .cs5_req_n           (cs5_req_n),
    .cs6_req_n           (cs6_req_n),
    .static_cs1_n        (static_cs1_n),
    .sdram_cs_n          (sdram_cs_n),
    .chip_select_three_n (chip_select_three_n),
    .chip_select_four_n  (chip_select_four_n),
    .chip_select_five_n  (chip_select_five_n),
    .chip_select_six_n   (chip_select_six_n),
    .nand_select         (nand_select),
    .card_select_four    (card_select_four),
    .card_select_five    (card_select_five)
  );

endmodule

// ### eb_pin_cs_config_bench.sv
// self-checking bench for the pin and chip select configuration register
`timescale 1ns/1ns
module eb_pin_cs_config_bench;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        en = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  gpio = 8'h00;
  logic [4:0]  req = 5'h1f;
  logic [7:0]  shp;
  logic        pu, s1, sd, c3, c4, c5, c6, ne, ce, ns, k4, k5;
  logic [31:0] m;
  logic [31:0] d;
  int          num_errors = 0;
  int          tests_run = 0;
  int          seed = 62;

  // free-running clock
  always #5 clock = ~clock;

  eb_pin_cs_config u_dut (.clock(clock), .rstn(rstn), .clk_en(en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_pullup_req(gpio), .data_bus_pullup_control(pu), .shared_pin_pullup(shp),
    .cs1_req_n(req[0]), .cs3_req_n(req[1]), .cs4_req_n(req[2]), .cs5_req_n(req[3]),
    .cs6_req_n(req[4]), .static_cs1_n(s1), .sdram_cs_n(sd), .chip_select_three_n(c3),
    .chip_select_four_n(c4), .chip_select_five_n(c5), .chip_select_six_n(c6),
    .nand_logic_enable(ne), .card_logic_enable(ce), .nand_select(ns),
    .card_select_four(k4), .card_select_five(k5));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data is only valid in the slot after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // drive requests, then compare every routed output one edge later
  task automatic cs(input logic [4:0] r, input logic [7:0] g);
    @(posedge clock);
    req <= r;
    gpio <= g;
    @(posedge clock);
    #1;
    chk({s1, sd}, {r[0] | m[1], r[0] | ~m[1]});
    chk({c3, ns, ne}, {r[1], m[3] & ~r[1], m[3]});
    chk({c4, c6, k4, ce}, {r[2], r[4], m[4] & ~r[2], m[4] | m[5]});
    chk({c5, k5}, {r[3], m[5] & ~r[3]});
    chk({shp, pu}, {g, m[8]});
  endtask

  // expected read-back word: only the assignment and pull-up fields survive
  function automatic logic [31:0] exp_word(input logic [31:0] v);
    exp_word = v & eb_pkg::CFG_MASK;
  endfunction

  // enable low for one edge: the write and the new requests must be ignored
  task automatic frz(input logic [31:0] v);
    logic [4:0] r0;
    r0 = req;
    @(posedge clock);
    en <= 1'b0;
    reg_addr <= eb_pkg::CFG_ADDR;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    req <= ~r0;
    @(posedge clock);
    en <= 1'b1;
    reg_wr <= 1'b0;
    #1;
    chk({s1, sd}, {r0[0] | m[1], r0[0] | ~m[1]});
    chk({c3, ns, c4, k4, c5, k5, c6}, {r0[1], m[3] & ~r0[1], r0[2], m[4] & ~r0[2], r0[3], m[5] & ~r0[3], r0[4]});
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence: corner words first, then random words
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    m = 32'h0;
    rd(eb_pkg::CFG_ADDR, d);
    chk(d, 32'h0);
    cs(5'h00, 8'ha5);
    for (int i = 0; i < 40; i++)
    begin
      d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0100 : $random(seed);
      wr(eb_pkg::CFG_ADDR, d);
      m = exp_word(d);
      wr(8'h10, ~d);
      rd(eb_pkg::CFG_ADDR, d);
      chk(d, m);
      rd(8'h10, d);
      chk(d, 32'h0);
      repeat (3) cs(5'($random(seed)), 8'($random(seed)));
      frz($random(seed));
      rd(eb_pkg::CFG_ADDR, d);
      chk(d, m);
      $display("test %0d done", i);
    end
    final_report;
  end

  // hang guard, far beyond the expected run
  initial
  begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule

// ### eb_pin_cs_config_chk.sv
// port checks for the pin and chip select configuration register
`timescale 1ns/1ns
module eb_pin_cs_config_chk
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  gpio_pullup_req,
  input wire logic        data_bus_pullup_control,
  input wire logic [7:0]  shared_pin_pullup,
  input wire logic        cs1_req_n,
  input wire logic        cs3_req_n,
  input wire logic        cs4_req_n,
  input wire logic        static_cs1_n,
  input wire logic        sdram_cs_n,
  input wire logic        chip_select_three_n,
  input wire logic        chip_select_four_n,
  input wire logic        nand_logic_enable,
  input wire logic        nand_select,
  input wire logic        card_logic_enable,
  input wire logic        card_select_four
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // a write taken at the config word
  sequence s_wr;
    clk_en && reg_wr && reg_addr == eb_pkg::CFG_ADDR;
  endsequence
  // derived outputs trail their source: the pull-up bit the written word by two edges, the shared pull-ups the request by one
  AST_PULLUP: assert property (s_wr ##1 clk_en |=>
    data_bus_pullup_control == $past(reg_wdata[8], 2)) else $error("pull-up bit lost");
  AST_SHARED: assert property (clk_en |=>
    shared_pin_pullup == $past(gpio_pullup_req)) else $error("shared pull-up wrong");
  // a select one request never reaches both controllers
  AST_CS1: assert property (clk_en && !cs1_req_n |=>
    static_cs1_n != sdram_cs_n) else $error("select one misrouted");
  AST_NAND: assert property (clk_en |=> chip_select_three_n == $past(cs3_req_n) &&
    nand_select == (nand_logic_enable && !$past(cs3_req_n))) else $error("nand path wrong");
  AST_CARD: assert property (clk_en |=> chip_select_four_n == $past(cs4_req_n) &&
    (!card_select_four || card_logic_enable)) else $error("card path wrong");
  AST_RSVD: assert property (clk_en && reg_rd |=>
    (reg_rdata & ~32'h0000_013a) == 32'h0) else $error("reserved bit read high");
  AST_RDIDLE: assert property (clk_en && !reg_rd |=>
    reg_rdata == 32'h0) else $error("read data outside slot");
endmodule

bind eb_pin_cs_config eb_pin_cs_config_chk u_chk (.clock, .rstn, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_pullup_req, .data_bus_pullup_control,
  .shared_pin_pullup, .cs1_req_n, .cs3_req_n, .cs4_req_n, .static_cs1_n, .sdram_cs_n,
  .chip_select_three_n, .chip_select_four_n, .nand_logic_enable, .nand_select,
  .card_logic_enable, .card_select_four);

// ### eb_pkg.sv
// shared constants for the external bus pin and chip select configuration block
package eb_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register index and byte address of the configuration word
  localparam logic [ADDR_W-1:0] CFG_INDEX = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_ADDR  = 8'h00;

  // field positions inside the configuration word
  localparam int unsigned CS1_POS    = 1;
  localparam int unsigned CS3_POS    = 3;
  localparam int unsigned CS4_POS    = 4;
  localparam int unsigned CS5_POS    = 5;
  localparam int unsigned PULLUP_POS = 8;

  // writable bits; everything else is reserved and reads as zero
  localparam logic [DATA_W-1:0] CFG_MASK  = 32'h0000_013a;

  // value after reset
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;

  // number of bus pins whose pull-up is shared with the general purpose io controller
  localparam int unsigned SHARED_PINS = 8;

  // chip select routing targets
  typedef enum logic {
    EB_TO_STATIC,
    EB_TO_SDRAM
  } eb_target_e;

endpackage
